// *** include/ctr_pkg.sv ***
// shared constants and carriers for the transmit / auto-reply block
package ctr_pkg;
  // ---------------------------------------------------------------
  // buffer geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_BUF      = 6;
  localparam int unsigned REGS_PER_BUF = 14;
  localparam int unsigned DATA_BYTES   = 8;

  // ---------------------------------------------------------------
  // per-buffer register selects
  // ---------------------------------------------------------------
  localparam logic [3:0] SEL_CTRL  = 4'h0;
  localparam logic [3:0] SEL_STANDARD_ID_HIGH_REG  = 4'h1;
  localparam logic [3:0] SEL_STANDARD_ID_LOW_REG  = 4'h2;
  localparam logic [3:0] SEL_EXTENDED_ID_HIGH_REG  = 4'h3;
  localparam logic [3:0] SEL_EXTENDED_ID_LOW_REG  = 4'h4;
  localparam logic [3:0] SEL_DLC   = 4'h5;
  localparam logic [3:0] SEL_DATA0 = 4'h6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_AUTO_REMOTE_REPLY_ENABLE = 2;
  localparam int unsigned CTRL_TRANSMIT_REQUEST = 3;
  localparam int unsigned CTRL_ERR   = 4;
  localparam int unsigned CTRL_LARB  = 5;
  localparam int unsigned CTRL_ABT   = 6;
  localparam int unsigned STANDARD_ID_LOW_REG_EXTENDED_ID_SELECT = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [5:0] DIR_RESET  = 6'h00;
  localparam logic [7:0] RDATA_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LEGACY    = 2'b00,
    MODE_ENH_FIXED = 2'b01,
    MODE_ENH_FIFO  = 2'b10
  } ctr_mode_t;

  typedef enum logic [1:0] {
    RES_OK       = 2'b00,
    RES_ARB_LOST = 2'b01,
    RES_ERROR    = 2'b10
  } ctr_res_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_WAIT = 2'b10
  } ctr_state_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  buf_idx;
    logic        ext;
    logic [10:0] sid;
    logic [17:0] eid;
    logic [3:0]  dlc;
    logic [63:0] data;
  } ctr_msg_t;

  typedef struct packed {
    ctr_res_t   res;
    logic [2:0] buf_idx;
  } ctr_result_t;
endpackage

// *** src/ctr_skid_buf.sv ***
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ctr_skid_buf #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [2];
  logic             rd_q;
  logic             wr_q;
  logic [1:0]       cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  if (WIDTH < 1) begin : g_chk
    $error("ctr_skid_buf: WIDTH must be at least 1");
  end

  // full and empty straight from the count
  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rd_q];

  // entry write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      if (push && !pop) cnt_q <= cnt_q + 2'd1;
      else if (pop && !push) cnt_q <= cnt_q - 2'd1;
    end
  end
endmodule
`default_nettype wire

// *** src/ctr_prio_pick.sv ***
// picks the pending buffer of highest priority (lowest index)
`timescale 1ns/1ps
`default_nettype none
module ctr_prio_pick #(
  parameter int unsigned N    = 6,
  parameter int unsigned IDXW = 3
) (
  input  wire logic [N-1:0]    pending,
  output logic                 any,
  output logic      [IDXW-1:0] idx
);
  if (N < 1 || N > (1 << IDXW)) begin : g_chk
    $error("ctr_prio_pick: N does not fit IDXW");
  end

  // scan from the top so the lowest set index wins
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        any = 1'b1;
        idx = IDXW'(i);
      end
    end
  end
endmodule
`default_nettype wire

// *** src/ctr_tx_core.sv ***
// transmit scheduling and auto remote-reply for six programmable buffers
//
// Contract
// RULE1 - in enhanced modes auto-reply needs transmit select and reply enable both set
// RULE2 - matching remote frame sets transmit request and queues the buffer unaided
// RULE3 - while transmit request is set, writes to that buffer are dropped
// RULE4 - firmware sets select and reply enable, ties a filter, preloads data
// RULE5 - firmware loads id, length and data only while request is clear
// RULE6 - setting transmit request clears aborted, arbitration-lost and error flags
// RULE7 - a request only marks pending; sending starts when bus is available
// RULE8 - with several pending, highest priority buffer goes first
// RULE9 - success clears request, sets done flag, interrupts if enabled
// RULE10 - on failure request stays set and exactly one failure flag sets
// RULE11 - error after start sets error and invalid-message flags, interrupts
// RULE12 - lost arbitration sets the arbitration-lost flag
// RULE13 - after reset all buffers receive; select bit makes one transmit
// RULE14 - failed buffers compete again at next bus-available while requested
`timescale 1ns/1ps
`default_nettype none
module ctr_tx_core #(
  parameter int unsigned NB = ctr_pkg::NUM_BUF
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire ctr_pkg::ctr_mode_t  can_mode,
  input  wire logic                dir_wr,
  input  wire logic [5:0]          dir_wdata,
  output logic      [5:0]          buffer_direction_select_reg,
  input  wire logic                reg_wr,
  input  wire logic [2:0]          reg_wbuf,
  input  wire logic [3:0]          reg_wsel,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic [2:0]          reg_rbuf,
  input  wire logic [3:0]          reg_rsel,
  output logic      [7:0]          reg_rdata,
  input  wire logic                abort_req,
  input  wire logic [5:0]          transmit_done_irq_enable,
  input  wire logic [5:0]          done_clr,
  input  wire logic                invalid_clr,
  output logic      [5:0]          transmit_done_flag,
  output logic                     invalid_message_irq_flag,
  output logic                     irq,
  output logic      [5:0]          transmit_request,
  input  wire logic                bus_available,
  input  wire logic                rtr_hit_valid,
  input  wire logic [2:0]          rtr_hit_buf,
  output ctr_pkg::ctr_msg_t        tx_msg,
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  input  wire logic                res_valid,
  input wire ctr_pkg::ctr_result_t res
);
  import ctr_pkg::*;

  if (NB != NUM_BUF) begin : g_chk
    $error("ctr_tx_core: only six buffers are supported");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  store_q [NUM_BUF][REGS_PER_BUF];
  logic [5:0]  dir_q;
  logic [5:0]  transmit_request_q;
  logic [5:0]  auto_remote_reply_enable_q;
  logic [5:0]  abt_q;
  logic [5:0]  larb_q;
  logic [5:0]  err_q;
  logic [5:0]  done_q;
  logic        inval_q;
  logic        irq_q;
  logic [7:0]  rdata_q;
  ctr_state_t  state_q;
  ctr_state_t  state_d;
  logic [2:0]  cur_q;
  ctr_msg_t    msg_q;
  ctr_msg_t    msg_d;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire        enh      = (can_mode == MODE_ENH_FIXED) || (can_mode == MODE_ENH_FIFO);
  wire        wbuf_ok  = (reg_wbuf < 3'(NUM_BUF));
  wire        wsel_ok  = (reg_wsel < 4'(REGS_PER_BUF));
  wire        wr_ok    = reg_wr && wbuf_ok && wsel_ok && !transmit_request_q[reg_wbuf]; // RULE3
  wire        busy     = (state_q != ST_IDLE);
  wire        res_take = res_valid && (state_q == ST_WAIT) && (res.buf_idx == cur_q);
  wire        res_ok   = res_take && (res.res == RES_OK);
  wire        res_lost = res_take && (res.res == RES_ARB_LOST);
  wire        res_err  = res_take && (res.res == RES_ERROR);
  wire [5:0]  pending  = enh ? (transmit_request_q & dir_q) : 6'h00; // RULE13
  wire        pick_any;
  wire [2:0]  pick_idx;
  wire        q_valid;
  wire        q_ready;

  // priority encoder over pending buffers
  ctr_prio_pick #(
    .N    (NUM_BUF),
    .IDXW (3)
  ) u_pick (
    .pending (pending),
    .any     (pick_any),
    .idx     (pick_idx)
  ); // RULE8

  // ---------------------------------------------------------------
  // direction select register
  // ---------------------------------------------------------------
  // all buffers start as receivers
  always_ff @(posedge clk) begin
    if (reset) begin
      dir_q <= DIR_RESET; // RULE13
    end else if (dir_wr) begin
      dir_q <= dir_wdata;
    end
  end

  // ---------------------------------------------------------------
  // buffer byte store
  // ---------------------------------------------------------------
  // id, length and data bytes; control byte lives in flags below
  always_ff @(posedge clk) begin
    if (wr_ok && (reg_wsel != SEL_CTRL)) begin
      store_q[reg_wbuf][reg_wsel] <= reg_wdata; // RULE3
    end
  end

  // ---------------------------------------------------------------
  // per-buffer request and status flags
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_BUF; i++) begin : g_buf
    wire hit      = wr_ok && (reg_wbuf == 3'(i));
    wire ctrl_wr  = hit && (reg_wsel == SEL_CTRL);
    wire fw_set   = ctrl_wr && reg_wdata[CTRL_TRANSMIT_REQUEST] && dir_q[i];
    wire auto_set = enh && rtr_hit_valid && (rtr_hit_buf == 3'(i))
                    && dir_q[i] && auto_remote_reply_enable_q[i] && !transmit_request_q[i]; // RULE1
    wire set_req  = fw_set || auto_set; // RULE2
    wire mine     = (cur_q == 3'(i));
    wire done_i   = res_ok && mine;
    wire lost_i   = res_lost && mine;
    wire err_i    = res_err && mine;
    wire abort_i  = abort_req && transmit_request_q[i] && !(busy && mine);

    // request, abort and failure flags
    always_ff @(posedge clk) begin
      if (reset) begin
        transmit_request_q[i] <= 1'b0;
        abt_q[i]   <= 1'b0;
        larb_q[i]  <= 1'b0;
        err_q[i]   <= 1'b0;
      end else if (set_req) begin
        transmit_request_q[i] <= 1'b1;
        abt_q[i]   <= 1'b0; // RULE6
        larb_q[i]  <= 1'b0; // RULE6
        err_q[i]   <= 1'b0; // RULE6
      end else if (done_i) begin
        transmit_request_q[i] <= 1'b0; // RULE9
      end else if (abort_i) begin
        transmit_request_q[i] <= 1'b0;
        abt_q[i]   <= 1'b1;
      end else if (lost_i) begin
        larb_q[i]  <= 1'b1; // RULE12 RULE10
      end else if (err_i) begin
        err_q[i]   <= 1'b1; // RULE11 RULE10
      end
    end

    // reply enable, written through the control byte
    always_ff @(posedge clk) begin
      if (reset) begin
        auto_remote_reply_enable_q[i] <= 1'b0;
      end else if (ctrl_wr) begin
        auto_remote_reply_enable_q[i] <= reg_wdata[CTRL_AUTO_REMOTE_REPLY_ENABLE];
      end
    end

    // sticky done flag, a new completion beats the clear
    always_ff @(posedge clk) begin
      if (reset) begin
        done_q[i] <= 1'b0;
      end else begin
        done_q[i] <= done_i || (done_q[i] && !done_clr[i]); // RULE9
      end
    end
  end

  // ---------------------------------------------------------------
  // invalid-message flag and interrupt
  // ---------------------------------------------------------------
  // error sets the flag; set wins over the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      inval_q <= 1'b0;
    end else begin
      inval_q <= res_err || (inval_q && !invalid_clr); // RULE11
    end
  end

  // interrupt from enabled done flags or invalid message
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|(done_q & transmit_done_irq_enable)) || inval_q; // RULE9 RULE11
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  wire [7:0] ctrl_byte = {1'b0, abt_q[reg_rbuf], larb_q[reg_rbuf], err_q[reg_rbuf],
                          transmit_request_q[reg_rbuf], auto_remote_reply_enable_q[reg_rbuf], 2'b00};
  wire       rbuf_ok   = (reg_rbuf < 3'(NUM_BUF));
  wire       rsel_ok   = (reg_rsel < 4'(REGS_PER_BUF));
  wire [7:0] rd_sel    = (reg_rsel == SEL_CTRL) ? ctrl_byte : store_q[reg_rbuf][reg_rsel];
  wire [7:0] rd_next   = (rbuf_ok && rsel_ok) ? rd_sel : RDATA_ZERO;

  // one-cycle registered read
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= RDATA_ZERO;
    end else begin
      rdata_q <= rd_next;
    end
  end

  // ---------------------------------------------------------------
  // message assembly for the picked buffer
  // ---------------------------------------------------------------
  always_comb begin
    msg_d         = '0;
    msg_d.buf_idx = pick_idx;
    msg_d.sid     = {store_q[pick_idx][SEL_STANDARD_ID_HIGH_REG], store_q[pick_idx][SEL_STANDARD_ID_LOW_REG][7:5]};
    msg_d.ext     = store_q[pick_idx][SEL_STANDARD_ID_LOW_REG][STANDARD_ID_LOW_REG_EXTENDED_ID_SELECT];
    msg_d.eid     = {store_q[pick_idx][SEL_STANDARD_ID_LOW_REG][1:0], store_q[pick_idx][SEL_EXTENDED_ID_HIGH_REG],
                     store_q[pick_idx][SEL_EXTENDED_ID_LOW_REG]};
    msg_d.dlc     = store_q[pick_idx][SEL_DLC][3:0];
    for (int b = 0; b < DATA_BYTES; b++) begin
      msg_d.data[8*b +: 8] = store_q[pick_idx][SEL_DATA0 + 4'(b)];
    end
  end

  // ---------------------------------------------------------------
  // transmit sequencer
  // ---------------------------------------------------------------
  // wait for bus, hand one message over, wait for its outcome
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (bus_available && pick_any) state_d = ST_LOAD; // RULE7 RULE14
      end
      ST_LOAD: begin
        if (q_ready) state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (res_take) state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  assign q_valid = (state_q == ST_LOAD);

  // sequencer state and latched message
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cur_q   <= 3'h0;
      msg_q   <= '0;
    end else begin
      state_q <= state_d;
      if ((state_q == ST_IDLE) && (state_d == ST_LOAD)) begin
        cur_q <= pick_idx; // RULE8
        msg_q <= msg_d;
      end
    end
  end

  // two-entry buffer towards the protocol engine
  ctr_skid_buf #(
    .WIDTH ($bits(ctr_msg_t))
  ) u_q (
    .clk       (clk),
    .reset     (reset),
    .in_data   (msg_q),
    .in_valid  (q_valid),
    .in_ready  (q_ready),
    .out_data  (tx_msg),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign buffer_direction_select_reg = dir_q;
  assign reg_rdata                   = rdata_q;
  assign transmit_done_flag          = done_q;
  assign invalid_message_irq_flag    = inval_q;
  assign irq                         = irq_q;
  assign transmit_request            = transmit_request_q;
endmodule
`default_nettype wire

// *** sim/ctr_tx_core_asserts.sv ***
// assertion checker for the transmit and auto-reply core
`timescale 1ns/1ps
`default_nettype none
module ctr_tx_core_asserts (
  input wire logic                 clk,
  input wire logic                 reset,
  input wire ctr_pkg::ctr_mode_t   can_mode,
  input wire logic [5:0]           buffer_direction_select_reg,
  input wire logic [5:0]           transmit_done_irq_enable,
  input wire logic [5:0]           transmit_done_flag,
  input wire logic                 invalid_message_irq_flag,
  input wire logic                 irq,
  input wire logic [5:0]           transmit_request,
  input wire logic                 bus_available,
  input wire logic                 rtr_hit_valid,
  input wire logic [2:0]           rtr_hit_buf,
  input wire ctr_pkg::ctr_msg_t    tx_msg,
  input wire logic                 tx_valid,
  input wire logic                 tx_ready,
  input wire logic                 res_valid,
  input wire ctr_pkg::ctr_result_t res
);
  import ctr_pkg::*;
  logic       fl_q;
  logic [2:0] fl_idx_q;
  // pending set, mask of the sent buffer, and a result for the buffer in flight
  wire  [5:0] dir  = buffer_direction_select_reg;
  wire  [5:0] pend = (can_mode != MODE_LEGACY) ? (dir & transmit_request) : 6'h00;
  wire  [5:0] sel1 = 6'h01 << tx_msg.buf_idx;
  wire        took = res_valid && fl_q && (res.buf_idx == fl_idx_q);
  // remembers which buffer is out on the bus
  always_ff @(posedge clk) begin
    if (reset) fl_q <= 1'b0;
    else if (tx_valid && tx_ready) fl_q <= 1'b1;
    else if (took) fl_q <= 1'b0;
    if (tx_valid && tx_ready) fl_idx_q <= tx_msg.buf_idx;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_clears: assert property ($fell(reset) |-> dir == DIR_RESET && transmit_request == 6'h00)
    else $error("direction or request not cleared by reset");
  a_hit_no_dir: assert property (rtr_hit_valid && !dir[rtr_hit_buf] && !transmit_request[rtr_hit_buf] |=>
    !transmit_request[$past(rtr_hit_buf)]) else $error("receive buffer took a remote reply");
  a_ok_done: assert property (took && res.res == RES_OK |=>
    !transmit_request[fl_idx_q] && transmit_done_flag[fl_idx_q]) else $error("success not recorded");
  a_arb_keeps: assert property (took && res.res == RES_ARB_LOST |=>
    transmit_request[fl_idx_q] && !$rose(invalid_message_irq_flag)) else $error("lost arbitration mishandled");
  a_err_flags: assert property (took && res.res == RES_ERROR |=>
    transmit_request[fl_idx_q] && invalid_message_irq_flag ##1 irq) else $error("error not flagged");
  a_done_irq: assert property ((|(transmit_done_flag & transmit_done_irq_enable)) |=> irq)
    else $error("enabled done flag gave no irq");
  a_bus_gate: assert property ($rose(tx_valid) |-> $past(bus_available, 2) || $past(bus_available, 3))
    else $error("send started without free bus");
  a_prio_pick: assert property ($rose(tx_valid) |-> ($past(pend, 2) & (sel1 - 6'h01)) == 6'h00
    && ($past(pend, 2) & sel1) != 6'h00) else $error("wrong buffer picked");
  c_ok: cover property (took && res.res == RES_OK);
  c_err: cover property (took && res.res == RES_ERROR);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule
bind ctr_tx_core ctr_tx_core_asserts i_chk (.*);
`default_nettype wire

// *** sim/ctr_engine_model.sv ***
// far-side bus engine: takes one message, reports its outcome later
`timescale 1ns/1ps
`default_nettype none
module ctr_engine_model (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               stall,
  input  wire ctr_pkg::ctr_res_t  res_code,
  input  wire ctr_pkg::ctr_msg_t  tx_msg,
  input  wire logic               tx_valid,
  output logic                    tx_ready,
  output logic                    res_valid,
  output ctr_pkg::ctr_result_t    res
);
  import ctr_pkg::*;
  logic       busy_q;
  logic [1:0] cnt_q;
  logic [2:0] idx_q;
  wire        fin = busy_q && (cnt_q == 2'd0);
  // no new word while stalled or while a frame is on the bus
  assign tx_ready = !stall && !busy_q;
  // frame time, then one result pulse; result lines scramble between pulses
  always @(posedge clk) begin
    res_valid <= !reset && fin;
    res <= reset ? '0 : (fin ? {res_code, idx_q} : ~res);
    if (reset) begin
      busy_q <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      busy_q <= 1'b1;
      cnt_q <= 2'd3;
      idx_q <= tx_msg.buf_idx;
    end else if (fin) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 2'd1;
    end
  end
endmodule
`default_nettype wire

// *** sim/ctr_tx_core_tb_top.sv ***
// self-checking bench for the transmit and auto-reply core
`timescale 1ns/1ps
`default_nettype none
module ctr_tx_core_tb_top;
  import ctr_pkg::*;
  logic clk, reset, dir_wr, reg_wr, abort_req, invalid_clr, bus_available, rtr_hit_valid, tx_valid, tx_ready;
  logic res_valid, irq, invalid_message_irq_flag, stall, chk_q;
  logic [5:0] dir_wdata, transmit_done_irq_enable, done_clr, buffer_direction_select_reg;
  logic [5:0] transmit_done_flag, transmit_request, mreq, mdone;
  logic [2:0] reg_wbuf, reg_rbuf, rtr_hit_buf, mb;
  logic [3:0] reg_wsel, reg_rsel;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [10:0] msid [6];
  logic [17:0] meid [6];
  logic [63:0] mdata [6];
  ctr_mode_t can_mode;
  ctr_res_t res_code;
  ctr_msg_t tx_msg;
  ctr_result_t res;
  int n_fail = 0;
  int n_tests = 0;
  integer seed = 32'h3951;
  ctr_tx_core i_dut (.*);
  ctr_engine_model i_eng (.*);
  // clock source
  always #12.5 clk = ~clk;
  function automatic logic [2:0] pick(input logic [5:0] p);
    for (int i = 5; i >= 0; i--) if (p[i]) pick = 3'(i);
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] b, input logic [3:0] s, input logic [7:0] d);
    reg_wr = 1'b1;
    {reg_wbuf, reg_wsel, reg_wdata} = {b, s, d};
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [2:0] b, input logic [3:0] s);
    {reg_rbuf, reg_rsel} = {b, s};
    repeat (2) @(posedge clk);
    #1 v = reg_rdata;
  endtask
  task automatic hit(input logic [2:0] b);
    rtr_hit_valid = 1'b1;
    rtr_hit_buf = b;
    @(posedge clk);
    #1 rtr_hit_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic load(input logic [2:0] b);
    msid[b] = 11'($random(seed));
    mdata[b] = {$random(seed), $random(seed)};
    meid[b] = 18'($random(seed));
    wr(b, SEL_STANDARD_ID_HIGH_REG, msid[b][10:3]);
    wr(b, SEL_STANDARD_ID_LOW_REG, {msid[b][2:0], 1'b0, b[0], 1'b0, meid[b][17:16]});
    wr(b, SEL_EXTENDED_ID_HIGH_REG, meid[b][15:8]);
    wr(b, SEL_EXTENDED_ID_LOW_REG, meid[b][7:0]);
    wr(b, SEL_DLC, 8'h08);
    for (int i = 0; i < 8; i++) wr(b, SEL_DATA0 + 4'(i), mdata[b][8*i +: 8]);
  endtask
  task automatic wait_res(input ctr_res_t c);
    int i;
    res_code = c;
    for (i = 0; i < 80; i++) begin
      @(posedge clk);
      if (res_valid === 1'b1) break;
    end
    chk(i < 80, 1'b1, "result timeout");
    #1;
  endtask
  // reference model: follows every handshake and result of the core
  always @(posedge clk) begin
    if (chk_q) begin
      chk(transmit_request, mreq, "request after result");
      chk(transmit_done_flag, mdone, "done after result");
    end
    chk_q = res_valid === 1'b1;
    if (res_valid === 1'b1 && res.res == RES_OK) begin
      mreq[res.buf_idx] = 1'b0;
      mdone[res.buf_idx] = 1'b1;
    end
    if (tx_valid && tx_ready) begin
      mb = tx_msg.buf_idx;
      chk(tx_msg.buf_idx, pick(mreq & buffer_direction_select_reg), "picked buffer");
      chk({tx_msg.ext, tx_msg.sid, tx_msg.eid, tx_msg.dlc}, {mb[0], msid[mb], meid[mb], 4'h8}, "header");
      chk(tx_msg.data, mdata[tx_msg.buf_idx], "data");
    end
  end
  // main sequence
  initial begin
    {clk, dir_wr, reg_wr, abort_req, invalid_clr, bus_available, rtr_hit_valid, stall, chk_q} = '0;
    {dir_wdata, transmit_done_irq_enable, done_clr, mreq, mdone, reg_wbuf, reg_rbuf, rtr_hit_buf} = '0;
    {reg_wsel, reg_rsel, reg_wdata} = '0;
    reset = 1'b1;
    can_mode = MODE_LEGACY;
    res_code = RES_OK;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    chk({buffer_direction_select_reg, transmit_request, irq, tx_valid}, 14'h0, "reset state");
    can_mode = MODE_ENH_FIXED;
    hit(3'd0);
    wr(3'd1, SEL_CTRL, 8'h08);
    chk(transmit_request, 6'h00, "receive buffers take no request");
    dir_wr = 1'b1;
    dir_wdata = 6'h3f;
    @(posedge clk);
    #1 dir_wr = 1'b0;
    chk(buffer_direction_select_reg, 6'h3f, "direction register");
    load(3'd5);
    load(3'd2);
    wr(3'd5, SEL_CTRL, 8'h08);
    wr(3'd2, SEL_CTRL, 8'h08);
    mreq = 6'h24;
    rd(3'd2, SEL_DLC);
    wr(3'd2, SEL_DLC, 8'h03);
    rd(3'd2, SEL_DLC);
    chk(v, 8'h08, "locked buffer kept its length");
    chk({tx_valid, transmit_request}, {1'b0, mreq}, "pending without bus");
    stall = 1'b1;
    bus_available = 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(tx_valid, 1'b1, "word held during stall");
    stall = 1'b0;
    wait_res(RES_ARB_LOST);
    res_code = RES_ERROR;
    rd(3'd2, SEL_CTRL);
    chk(v, 8'h28, "arbitration lost flag");
    wait_res(RES_ERROR);
    chk(invalid_message_irq_flag, 1'b1, "invalid flag");
    res_code = RES_OK;
    rd(3'd2, SEL_CTRL);
    chk({v[4], irq}, 2'b11, "error flag and irq");
    wait_res(RES_OK);
    wait_res(RES_OK);
    invalid_clr = 1'b1;
    transmit_done_irq_enable = 6'h04;
    @(posedge clk);
    #1 invalid_clr = 1'b0;
    @(posedge clk);
    #1 chk(irq, 1'b1, "done irq");
    done_clr = 6'h04;
    mdone[2] = 1'b0;
    @(posedge clk);
    #1 done_clr = 6'h00;
    @(posedge clk);
    #1 chk({irq, invalid_message_irq_flag}, 2'b00, "irq cleared");
    wr(3'd2, SEL_CTRL, 8'h08);
    mreq[2] = 1'b1;
    rd(3'd2, SEL_CTRL);
    chk(v, 8'h08, "new request clears failure flags");
    wait_res(RES_OK);
    bus_available = 1'b0;
    // abort sets its flag; a fresh request must clear it again
    for (int k = 0; k < 2; k++) begin
      wr(3'd1, SEL_CTRL, 8'h08);
      rd(3'd1, SEL_CTRL);
      chk(v, 8'h08, "request clears abort flag");
      abort_req = 1'b1;
      @(posedge clk);
      #1 abort_req = 1'b0;
      rd(3'd1, SEL_CTRL);
      chk({v, transmit_request}, {8'h40, mreq}, "abort drops request");
    end
    load(3'd4);
    wr(3'd4, SEL_CTRL, 8'h04);
    for (int k = 1; k < 3; k++) begin
      can_mode = ctr_mode_t'(k);
      hit(3'd3);
      hit(3'd4);
      mreq[4] = 1'b1;
      chk(transmit_request, mreq, "auto reply request");
      bus_available = 1'b1;
      wait_res(RES_OK);
      bus_available = 1'b0;
    end
    can_mode = MODE_LEGACY;
    hit(3'd4);
    chk(transmit_request, 6'h00, "no auto reply in legacy mode");
    finish_test();
  end
  // cuts a hung run short
  initial begin
    #(25 * 3000);
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
